/* File: adc_startup_sequencer.sv */
`timescale 1ns/1ps
// Functional notes
// R1: bring up all three supply rails first, in any order.
// R2: start the system reference after supplies, before the reset pulse.
// R3: reset is one high-going pulse: low, high, low; active high.
// R4: write the analog trim script first after every power-up.
// R5: write interleave calibration script, channel A then channel B.
// R6: wait 50 ms for interleave error estimation before more writes.
// R7: then write nonlinearity scripts, channel A then channel B.
// R8: finally write the down-converter and serial link script.
// R9: wait at least 1 ms after power-up before the reset pulse.
// R10: hold reset high at least 1 us.
// R11: wait at least 100 ns after reset falls before port select.
// R12: this order applies in bypass mode, 12-bit, link set 82820.
// R13: device resets registers on the pulse, accepts writes after release.
module adc_startup_sequencer #(
   parameter int unsigned     POWER_ON_CYCLES  = startup_seq_pkg::POWER_ON_CYCLES,
   parameter longint unsigned IL_SETTLE_CYCLES = startup_seq_pkg::IL_SETTLE_CYCLES,
   parameter int unsigned     RESET_CYCLES     = startup_seq_pkg::RESET_CYCLES,
   parameter int unsigned     WRITE_GAP_CYCLES = startup_seq_pkg::WRITE_GAP_CYCLES
) (
   input  wire logic       core_clk,          // 40 MHz system clock
   input  wire logic       reset_n,           // sync reset, active low
   input  wire logic       start,             // pulse: begin power-up sequence
   input  wire logic       railsGood,         // all supply rails in regulation
   input  wire logic [1:0] nyquistZone,       // zone chooser for cal scripts
   input  wire logic       scriptDone,        // pulse: writer finished a script
   input  wire logic       scriptError,       // pulse: writer failed a script
   output logic            railEnable1v15,    // 1.15 V rail enable
   output logic            railEnable1v2,     // 1.2 V rail enable
   output logic            railEnable1v9,     // 1.9 V rail enable
   output logic            sysrefEnable,      // system reference running
   output logic            adcReset,          // device hardware reset, active high
   output logic            writeAllowed,      // serial port select may assert
   output logic            scriptStart,       // pulse: run selected script
   output logic [2:0]      scriptSel,         // script to run
   output logic [1:0]      scriptZone,        // zone for cal scripts
   output logic            seqBusy,           // sequence in progress
   output logic            seqDone,           // device configured
   output logic            seqFail            // writer reported an error
);

   localparam int CW = startup_seq_pkg::CNT_W;

   typedef struct packed
   {
      startup_seq_pkg::seq_state_t state;
      startup_seq_pkg::script_t    script;
      logic [1:0]                  zone;
      logic                        rails;
      logic                        sysref;
      logic                        rst;
      logic                        allow;
      logic                        kick;
      logic                        done;
      logic                        fail;
      logic                        busy;
      logic                        tload;
      logic [CW-1:0]               tcount;
   } seq_reg_t;

   seq_reg_t cur;
   seq_reg_t next_cur;
   logic     tExpired;

   // cycle count cut to the timer width
   function automatic logic [CW-1:0] cyc(input longint unsigned n);
      cyc = CW'(n);
   endfunction : cyc

   // next script in the fixed order
   function automatic startup_seq_pkg::script_t nextScript(
      input startup_seq_pkg::script_t s);
      case (s)
         startup_seq_pkg::SCRIPT_TRIM: nextScript = startup_seq_pkg::SCRIPT_IL_A;
         startup_seq_pkg::SCRIPT_IL_A: nextScript = startup_seq_pkg::SCRIPT_IL_B;
         startup_seq_pkg::SCRIPT_NL_A: nextScript = startup_seq_pkg::SCRIPT_NL_B;
         startup_seq_pkg::SCRIPT_NL_B: nextScript = startup_seq_pkg::SCRIPT_DDCJES;
         default:                      nextScript = startup_seq_pkg::SCRIPT_TRIM;
      endcase
   endfunction : nextScript

   cycle_timer #(
      .CNT_W   (CW)
   ) u_timer (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .load     (cur.tload),
      .count    (cur.tcount),
      .expired  (tExpired)
   );

   // sequencer next-state
   always_comb
   begin
      next_cur       = cur;
      next_cur.kick  = 1'b0;
      next_cur.tload = 1'b0;
      case (cur.state)
         startup_seq_pkg::ST_IDLE:
         begin
            if (start)
            begin
               next_cur.rails = 1'b1;                          // R1
               next_cur.rst   = 1'b0;                          // R3
               next_cur.done  = 1'b0;
               next_cur.fail  = 1'b0;
               next_cur.allow = 1'b0;
               next_cur.zone  = nyquistZone;                   // R12
               next_cur.state = startup_seq_pkg::ST_POWER;
            end
         end
         startup_seq_pkg::ST_POWER:
         begin
            if (railsGood)
            begin
               next_cur.sysref = 1'b1;                         // R2
               next_cur.tload  = 1'b1;
               next_cur.tcount = cyc(longint'(POWER_ON_CYCLES)); // R9
               next_cur.state  = startup_seq_pkg::ST_REFWAIT;
            end
         end
         startup_seq_pkg::ST_REFWAIT:
         begin
            if (tExpired)
            begin
               next_cur.rst    = 1'b1;                         // R3
               next_cur.tload  = 1'b1;
               next_cur.tcount = cyc(longint'(RESET_CYCLES));  // R10
               next_cur.state  = startup_seq_pkg::ST_RESET_HI;
            end
         end
         startup_seq_pkg::ST_RESET_HI:
         begin
            if (tExpired)
            begin
               next_cur.rst    = 1'b0;                         // R3
               next_cur.tload  = 1'b1;
               next_cur.tcount = cyc(longint'(WRITE_GAP_CYCLES)); // R11
               next_cur.state  = startup_seq_pkg::ST_POSTRESET;
            end
         end
         startup_seq_pkg::ST_POSTRESET:
         begin
            if (tExpired)
            begin
               next_cur.allow  = 1'b1;                         // R11 R13
               next_cur.script = startup_seq_pkg::SCRIPT_TRIM; // R4
               next_cur.state  = startup_seq_pkg::ST_SCRIPT;
            end
         end
         startup_seq_pkg::ST_SCRIPT:
         begin
            next_cur.kick  = 1'b1;
            next_cur.state = startup_seq_pkg::ST_SCRIPTWT;
         end
         startup_seq_pkg::ST_SCRIPTWT:
         begin
            if (scriptError)
            begin
               next_cur.fail  = 1'b1;
               next_cur.state = startup_seq_pkg::ST_FAIL;
            end
            else if (scriptDone)
            begin
               if (cur.script == startup_seq_pkg::SCRIPT_IL_B)
               begin
                  next_cur.tload  = 1'b1;
                  next_cur.tcount = cyc(IL_SETTLE_CYCLES);     // R6
                  next_cur.state  = startup_seq_pkg::ST_SETTLE;
               end
               else if (cur.script == startup_seq_pkg::SCRIPT_DDCJES)
               begin
                  next_cur.done  = 1'b1;                       // R8
                  next_cur.state = startup_seq_pkg::ST_DONE;
               end
               else
               begin
                  next_cur.script = nextScript(cur.script);    // R5 R7
                  next_cur.state  = startup_seq_pkg::ST_SCRIPT;
               end
            end
         end
         startup_seq_pkg::ST_SETTLE:
         begin
            if (tExpired)
            begin
               next_cur.script = startup_seq_pkg::SCRIPT_NL_A; // R7
               next_cur.state  = startup_seq_pkg::ST_SCRIPT;
            end
         end
         startup_seq_pkg::ST_DONE,
         startup_seq_pkg::ST_FAIL:
         begin
            if (start)
            begin
               next_cur.state = startup_seq_pkg::ST_IDLE;
            end
         end
         default:
         begin
            next_cur.state = startup_seq_pkg::ST_IDLE;
         end
      endcase
      // busy flag kept in a flop so the output carries no decode
      next_cur.busy = (next_cur.state != startup_seq_pkg::ST_IDLE)
                   && !next_cur.done && !next_cur.fail;
   end

   // state register
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         cur        <= '0;
         cur.state  <= startup_seq_pkg::ST_IDLE;
         cur.script <= startup_seq_pkg::SCRIPT_TRIM;
      end
      else
      begin
         cur <= next_cur;
      end
   end

   // outputs straight from state flops
   assign railEnable1v15 = cur.rails;
   assign railEnable1v2  = cur.rails;
   assign railEnable1v9  = cur.rails;
   assign sysrefEnable   = cur.sysref;
   assign adcReset       = cur.rst;
   assign writeAllowed   = cur.allow;
   assign scriptStart    = cur.kick;
   assign scriptSel      = cur.script;
   assign scriptZone     = cur.zone;
   assign seqDone        = cur.done;
   assign seqFail        = cur.fail;
   assign seqBusy        = cur.busy;

endmodule : adc_startup_sequencer

/* File: startup_seq_pkg.sv */
package startup_seq_pkg;

   // minimum times of the power-up sequence, up to the interleave settle
   localparam int unsigned CLK_PERIOD_PS      = 25000;
   localparam int unsigned POWER_ON_DELAY_US  = 1000;
   localparam int unsigned RESET_PULSE_NS     = 1000;
   localparam int unsigned REG_WRITE_DELAY_NS = 100;
   localparam int unsigned IL_SETTLE_MS       = 50;

   // cycle counts, least times rounded up
   localparam int unsigned POWER_ON_CYCLES  =
      (POWER_ON_DELAY_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned RESET_CYCLES     =
      (RESET_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned WRITE_GAP_CYCLES =
      (REG_WRITE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam longint unsigned IL_SETTLE_CYCLES =
      (64'(IL_SETTLE_MS) * 1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   localparam int CNT_W = 32;

   // script selector handed to the register writer
   typedef enum logic [2:0]
   {
      SCRIPT_TRIM   = 3'h0,
      SCRIPT_IL_A   = 3'h1,
      SCRIPT_IL_B   = 3'h2,
      SCRIPT_NL_A   = 3'h3,
      SCRIPT_NL_B   = 3'h4,
      SCRIPT_DDCJES = 3'h5
   } script_t;

   // sequencer states
   typedef enum logic [3:0]
   {
      ST_IDLE      = 4'h0,
      ST_POWER     = 4'h1,
      ST_REFWAIT   = 4'h2,
      ST_RESET_LO  = 4'h3,
      ST_RESET_HI  = 4'h4,
      ST_POSTRESET = 4'h5,
      ST_SCRIPT    = 4'h6,
      ST_SCRIPTWT  = 4'h7,
      ST_SETTLE    = 4'h8,
      ST_DONE      = 4'h9,
      ST_FAIL      = 4'hA
   } seq_state_t;

endpackage : startup_seq_pkg

/* File: cycle_timer.sv */
`timescale 1ns/1ps
// down counter: load a count, flags expiry
module cycle_timer #(
   parameter int CNT_W = 32
) (
   input  wire logic             core_clk,  // system clock
   input  wire logic             reset_n,   // sync reset, active low
   input  wire logic             load,      // load new count
   input  wire logic [CNT_W-1:0] count,     // cycles to wait
   output logic                  expired    // count has run out
);

   typedef struct packed
   {
      logic [CNT_W-1:0] remain;
   } timer_state_t;

   timer_state_t cur;
   timer_state_t next_cur;

   // next count
   always_comb
   begin
      next_cur = cur;
      if (load)
      begin
         next_cur.remain = count;
      end
      else if (cur.remain != '0)
      begin
         next_cur.remain = cur.remain - CNT_W'(1);
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         cur <= '0;
      end
      else
      begin
         cur <= next_cur;
      end
   end

   assign expired = (cur.remain == '0) && !load;

endmodule : cycle_timer

/* File: adc_startup_sequencer_asserts.sv */
`timescale 1ns/1ps
// timing and order watch on the startup controller outputs
module adc_startup_sequencer_asserts #(
   parameter int unsigned     POWER_ON_CYCLES  = 20,
   parameter longint unsigned IL_SETTLE_CYCLES = 30,
   parameter int unsigned     RESET_CYCLES     = 4,
   parameter int unsigned     WRITE_GAP_CYCLES = 4
) (
   input wire logic       core_clk,       // clock
   input wire logic       reset_n,        // sync reset, active low
   input wire logic       start,          // sequence start
   input wire logic       railsGood,      // rails settled
   input wire logic [1:0] nyquistZone,    // zone chooser
   input wire logic       scriptDone,     // writer finished
   input wire logic       scriptError,    // writer failed
   input wire logic       railEnable1v15, // rail enable
   input wire logic       railEnable1v2,  // rail enable
   input wire logic       railEnable1v9,  // rail enable
   input wire logic       sysrefEnable,   // reference running
   input wire logic       adcReset,       // device reset
   input wire logic       writeAllowed,   // port select allowed
   input wire logic       scriptStart,    // script launch
   input wire logic [2:0] scriptSel,      // script chosen
   input wire logic [1:0] scriptZone,     // zone copy
   input wire logic       seqBusy,        // in progress
   input wire logic       seqDone,        // configured
   input wire logic       seqFail         // writer error
);
   logic [31:0] onCnt, hiCnt, loCnt, dnCnt;
   logic [2:0]  lastSel;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // elapsed cycles for the minimum waits, last script launched
   always_ff @(posedge core_clk)
   begin
      onCnt   <= (reset_n && railEnable1v15) ? onCnt + 1 : '0;
      hiCnt   <= (reset_n && adcReset) ? hiCnt + 1 : '0;
      loCnt   <= (reset_n && !adcReset) ? loCnt + 1 : '0;
      dnCnt   <= (reset_n && !scriptDone) ? dnCnt + 1 : '0;
      lastSel <= !reset_n ? 3'h0 : scriptStart ? scriptSel : lastSel;
   end
   a_rails_together: assert property (railEnable1v2 == railEnable1v15 &&
      railEnable1v9 == railEnable1v15) else $error("rail enables differ");
   a_sysref_after_rails: assert property ($rose(sysrefEnable) |->
      railEnable1v15 && $past(railsGood)) else $error("sysref before rails");
   a_power_on_wait: assert property ($rose(adcReset) |->
      sysrefEnable && onCnt >= POWER_ON_CYCLES) else $error("reset pulse too early");
   a_reset_width: assert property ($fell(adcReset) |-> hiCnt >= RESET_CYCLES)
      else $error("reset pulse too short");
   a_write_gap: assert property ($rose(writeAllowed) |->
      !adcReset && loCnt >= WRITE_GAP_CYCLES) else $error("write gap too short");
   a_trim_first: assert property ($rose(writeAllowed) |=>
      scriptStart && scriptSel == 3'h0) else $error("trim script not first");
   a_script_order: assert property (scriptStart && scriptSel != 3'h0 |->
      scriptSel == lastSel + 3'h1) else $error("script out of order");
   a_settle_wait: assert property (scriptStart && scriptSel == 3'h3 |->
      dnCnt >= IL_SETTLE_CYCLES) else $error("settle wait too short");
   a_done_last: assert property ($rose(seqDone) |-> lastSel == 3'h5 && !seqFail)
      else $error("done before link script");
   cover property ($rose(seqDone));
   cover property ($rose(seqFail));
   cover property ($fell(adcReset));
endmodule : adc_startup_sequencer_asserts

bind adc_startup_sequencer adc_startup_sequencer_asserts #(
   .POWER_ON_CYCLES(POWER_ON_CYCLES), .IL_SETTLE_CYCLES(IL_SETTLE_CYCLES),
   .RESET_CYCLES(RESET_CYCLES), .WRITE_GAP_CYCLES(WRITE_GAP_CYCLES))
   adc_startup_sequencer_asserts_i (.core_clk(core_clk), .reset_n(reset_n), .start(start),
   .railsGood(railsGood), .nyquistZone(nyquistZone), .scriptDone(scriptDone),
   .scriptError(scriptError), .railEnable1v15(railEnable1v15), .railEnable1v2(railEnable1v2),
   .railEnable1v9(railEnable1v9), .sysrefEnable(sysrefEnable), .adcReset(adcReset),
   .writeAllowed(writeAllowed), .scriptStart(scriptStart), .scriptSel(scriptSel),
   .scriptZone(scriptZone), .seqBusy(seqBusy), .seqDone(seqDone), .seqFail(seqFail));

/* File: adc_cfg_model.sv */
`timescale 1ns/1ps
// converter with its register writer, as the controller sees it
module adc_cfg_model (
   input  wire logic       core_clk,    // clock
   input  wire logic       reset_n,     // sync reset
   input  wire logic       railOn,      // all rails enabled
   input  wire logic       adcReset,    // hardware reset
   input  wire logic       scriptStart, // run a script
   input  wire logic [2:0] scriptSel,   // script chosen
   input  wire logic [2:0] failSel,     // script to refuse
   input  wire logic [3:0] lat,         // writer latency
   output logic            railsGood,   // rails settled
   output logic            scriptDone,  // script written
   output logic            scriptError  // script refused
);
   logic       busy;
   logic [3:0] cnt;
   logic [2:0] sel;
   // rails settle a cycle after enable; a reset pulse drops any write in flight
   always_ff @(posedge core_clk)
   begin
      railsGood   <= reset_n && railOn;
      scriptDone  <= 1'b0;
      scriptError <= 1'b0;
      if (!reset_n || adcReset)
         busy <= 1'b0;
      else if (scriptStart)
      begin
         busy <= 1'b1;
         cnt  <= lat;
         sel  <= scriptSel;
      end
      else if (busy && cnt != 4'h0)
         cnt <= cnt - 4'h1;
      else if (busy)
      begin
         busy        <= 1'b0;
         scriptError <= sel == failSel;
         scriptDone  <= sel != failSel;
      end
   end
endmodule : adc_cfg_model

/* File: adc_startup_reset_sequencer_tb_top.sv */
`timescale 1ns/1ps
// startup controller driven against the converter model
module adc_startup_reset_sequencer_tb_top;
   logic       core_clk, reset_n, start, railsGood, scriptDone, scriptError;
   logic       railEnable1v15, railEnable1v2, railEnable1v9, sysrefEnable, adcReset;
   logic       writeAllowed, scriptStart, seqBusy, seqDone, seqFail;
   logic [1:0] nyquistZone, zone, scriptZone;
   logic [2:0] scriptSel, failSel;
   logic [3:0] lat;
   logic [7:0] expQ[$];
   int         fails, testsRun, seed;

   adc_startup_sequencer #(.POWER_ON_CYCLES(20), .IL_SETTLE_CYCLES(30), .RESET_CYCLES(4),
      .WRITE_GAP_CYCLES(4)) adc_startup_sequencer_i (.core_clk(core_clk), .reset_n(reset_n),
      .start(start), .railsGood(railsGood), .nyquistZone(nyquistZone),
      .scriptDone(scriptDone), .scriptError(scriptError), .railEnable1v15(railEnable1v15),
      .railEnable1v2(railEnable1v2), .railEnable1v9(railEnable1v9),
      .sysrefEnable(sysrefEnable), .adcReset(adcReset), .writeAllowed(writeAllowed),
      .scriptStart(scriptStart), .scriptSel(scriptSel), .scriptZone(scriptZone),
      .seqBusy(seqBusy), .seqDone(seqDone), .seqFail(seqFail));
   adc_cfg_model adc_cfg_model_i (.core_clk(core_clk), .reset_n(reset_n),
      .railOn(railEnable1v15 & railEnable1v2 & railEnable1v9), .adcReset(adcReset),
      .scriptStart(scriptStart), .scriptSel(scriptSel), .failSel(failSel), .lat(lat),
      .railsGood(railsGood), .scriptDone(scriptDone), .scriptError(scriptError));

   // 25 ns clock
   initial core_clk = 1'b0;
   always #12.5 core_clk = ~core_clk;

   task automatic chk(input string name, input logic [7:0] e, input logic [7:0] s);
      testsRun++;
      if (s !== e)
      begin
         fails++;
         $display("Error %s expected %h seen %h", name, e, s);
      end
   endtask : chk

   task automatic completeRun;
      $display("comparisons %0d mismatches %0d", testsRun, fails);
      if (fails == 0 && testsRun > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : completeRun

   task automatic pulse;
      @(negedge core_clk) start = 1'b1;
      @(negedge core_clk) start = 1'b0;
   endtask : pulse

   // each script launch is matched with the oldest noted script, looked at mid-cycle
   always @(negedge core_clk)
      if (scriptStart === 1'b1)
      begin
         chk("scriptSel", expQ.size() ? expQ.pop_front() : 8'hff, {5'h0, scriptSel});
         chk("scriptZone", {6'h0, zone}, {6'h0, scriptZone});
      end

   // one sequence; f names the refused script, abort cuts it short by reset
   task automatic run(input logic [2:0] f, input int abort);
      int i;
      if (seqDone === 1'b1 || seqFail === 1'b1)
         pulse();
      @(negedge core_clk);
      zone = $random(seed);
      lat = $random(seed);
      failSel = f;
      nyquistZone = zone;
      for (i = 0; i < 6 && i <= f; i++)
         expQ.push_back(8'(i));
      pulse();
      repeat (3) @(negedge core_clk);
      nyquistZone = ~zone;
      pulse();
      chk("early outputs", 8'hf2, {railEnable1v15, railEnable1v2, railEnable1v9,
         sysrefEnable, adcReset, writeAllowed, seqBusy, seqDone});
      if (abort > 0)
      begin
         repeat (abort) @(negedge core_clk);
         reset_n = 1'b0;
         repeat (2) @(negedge core_clk);
         chk("outputs", 8'h00, {railEnable1v15, sysrefEnable, adcReset, writeAllowed,
            scriptStart, seqBusy, seqDone, seqFail});
         reset_n = 1'b1;
         expQ.delete();
      end
      else
      begin
         for (i = 0; i < 2000 && seqDone !== 1'b1 && seqFail !== 1'b1; i++)
            @(negedge core_clk);
         chk("seqDone", {7'h0, f == 3'h7}, {7'h0, seqDone});
         chk("seqFail", {7'h0, f != 3'h7}, {7'h0, seqFail});
         chk("pending", 8'h00, 8'(expQ.size()));
      end
   endtask : run

   // full run, refused script after settle, reset mid-run, full run again
   initial
   begin
      reset_n = 1'b0;
      start = 1'b0;
      nyquistZone = 2'h0;
      zone = 2'h0;
      failSel = 3'h7;
      lat = 4'h0;
      seed = 15125;
      repeat (8) @(negedge core_clk);
      reset_n = 1'b1;
      run(3'h7, 0);
      run(3'h3, 0);
      run(3'h7, 45);
      run(3'h7, 0);
      completeRun();
   end

   // watchdog
   initial
   begin
      repeat (20000) @(posedge core_clk);
      fails++;
      completeRun();
   end
endmodule : adc_startup_reset_sequencer_tb_top
